// [rtl/user_ctrl_pkg.sv]
// Purpose: constants for user control and power management register logic
// Assumes: 8-bit registers reached over a simple internal write/read port
// Notes:   reset values are shared with the bench
package user_ctrl_pkg;
    localparam logic [6:0] user_control_addr         = 7'h6a;
    localparam logic [6:0] power_management_one_addr = 7'h6b;
    localparam logic [7:0] user_control_reset        = 8'h00;
    localparam int         queue_operate_bit         = 6;
    localparam int         aux_master_on_bit         = 5;
    localparam int         serial_slave_disable_bit  = 4;
    localparam int         queue_clear_bit           = 2;
    localparam int         aux_master_reset_bit      = 1;
    localparam int         signal_condition_reset_bit = 0;
    localparam int         full_reset_bit            = 7;
    localparam int         sleep_bit                 = 6;
    localparam logic [7:0] pm1_low_reset             = 8'h01;
    localparam int         core_clk_hz               = 10_000_000;
    localparam int         fast_8k_rate_code         = 0;
endpackage : user_ctrl_pkg

// [rtl/user_control_power_reset_logic.sv]
// Purpose: user control and power management one register behaviour
// Assumes: register port is on core_clk; the 8 MHz tick comes as a pin
// Notes:   reset pulses last one internal_8mhz_clock period
// What this block does
// - queue operate bit set enables sample-queue operation
// - queue operate clear drops queue_enable and also blocks the host queue grant
// - aux master on runs master, isolates aux pins from primary pins
// - aux master off drives aux pins from primary serial pins
// - motion processor runs when enabled unless sample rate is 8 kHz
// - serial slave disable resets I2C slave and forces SPI-only mode
// - serial slave disable bit clears itself one internal clock later
// - queue clear resets queue asynchronously, bit clears after one clock
// - aux master reset resets master asynchronously, bit self clears
// - signal condition reset resets sensor paths and clears results
// - signal condition reset is one internal 8 MHz period wide
// - full reset bit restores all registers to defaults, self clears
// - sleep bit set keeps device in sleep mode
// - after configuration load, powerup sleep setting copies into sleep
// - result allocation recomputed only when all slaves off or master reset
`timescale 1ns/1ns
module user_control_power_reset_logic (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       internal_8mhz_clock,
    input  wire logic       reg_wr,
    input  wire logic [6:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic       otp_loaded,
    input  wire logic       powerup_sleep_setting,
    input  wire logic       motion_processor_enable,
    input  wire logic       rate_is_8khz,
    input  wire logic       all_slaves_disabled,
    input  wire logic       host_queue_req,
    input  wire logic       primary_sda_in,
    input  wire logic       primary_scl_in,
    input  wire logic       master_sda_out,
    input  wire logic       master_sda_oe,
    input  wire logic       master_scl_out,
    input  wire logic       master_scl_oe,
    output logic            aux_data_pin_out,
    output logic            aux_data_pin_oe,
    output logic            aux_clock_pin_out,
    output logic            aux_clock_pin_oe,
    output logic            queue_enable,
    output logic            host_queue_grant,
    output logic            aux_master_run,
    output logic            motion_processor_run,
    output logic            spi_only,
    output logic            serial_slave_reset,
    output logic            queue_reset,
    output logic            aux_master_reset_out,
    output logic            signal_condition_pulse,
    output logic            result_clear,
    output logic            realloc_results,
    output logic            full_reset_out,
    output logic            sleep_mode
);
    logic       tick_s1_ff, tick_s2_ff, tick_s3_ff;
    logic       sda_s1_ff, sda_s2_ff, scl_s1_ff, scl_s2_ff;
    logic       queue_on_ff, master_on_ff, spi_only_ff;
    logic       slave_dis_ff, qclr_ff, mrst_ff, scond_ff, hreset_ff;
    logic       slave_dis_arm_ff, qclr_arm_ff, mrst_arm_ff, scond_arm_ff;
    logic       hreset_arm_ff;
    logic       sleep_ff, otp_done_ff;
    logic [5:0] pm1_low_ff;
    logic       tick;
    logic       wr_user, wr_pm1, soft_rst_n;
    logic       sel_user, sel_pm1;

    // register address match, shared by write decode and read mux
    function automatic logic addr_match(input logic [6:0] addr,
                                        input logic [6:0] reg_at);
        return addr == reg_at;
    endfunction : addr_match

    // 8 MHz edge found from a synchronised copy
    // no reset here: the free-running pins refill these within three clocks
    always_ff @(posedge core_clk) begin
        tick_s1_ff <= internal_8mhz_clock;
        tick_s2_ff <= tick_s1_ff;
        tick_s3_ff <= tick_s2_ff;
        sda_s1_ff  <= primary_sda_in;
        sda_s2_ff  <= sda_s1_ff;
        scl_s1_ff  <= primary_scl_in;
        scl_s2_ff  <= scl_s1_ff;
    end

    assign tick       = tick_s2_ff & ~tick_s3_ff;
    assign sel_user   = addr_match(reg_addr,
                                   user_ctrl_pkg::user_control_addr);
    assign sel_pm1    = addr_match(reg_addr,
                                   user_ctrl_pkg::power_management_one_addr);
    assign wr_user    = reg_wr & sel_user;
    assign wr_pm1     = reg_wr & sel_pm1;
    assign soft_rst_n = rst_n & ~hreset_ff;

    // persistent control bits
    always_ff @(posedge core_clk) begin
        if (!soft_rst_n) begin
            queue_on_ff  <= 1'b0;
            master_on_ff <= 1'b0;
            spi_only_ff  <= 1'b0;
            pm1_low_ff   <= user_ctrl_pkg::pm1_low_reset[5:0];
        end else begin
            if (wr_user) begin
                queue_on_ff  <= reg_wdata[user_ctrl_pkg::queue_operate_bit];
                master_on_ff <= reg_wdata[user_ctrl_pkg::aux_master_on_bit];
            end
            if (wr_user && reg_wdata[user_ctrl_pkg::serial_slave_disable_bit])
                spi_only_ff <= 1'b1;
            if (wr_pm1)
                pm1_low_ff <= reg_wdata[5:0];
        end
    end

    // sleep copies the powerup setting once after configuration load
    always_ff @(posedge core_clk) begin
        if (!soft_rst_n) begin
            sleep_ff    <= 1'b0;
            otp_done_ff <= 1'b0;
        end else if (otp_loaded && !otp_done_ff) begin
            sleep_ff    <= powerup_sleep_setting;
            otp_done_ff <= 1'b1;
        end else if (wr_pm1) begin
            sleep_ff <= reg_wdata[user_ctrl_pkg::sleep_bit];
        end
    end

    // self-clearing pulses: armed by a write outside the tick cycle, raised at next tick, dropped after
    // only rst_n clears these, so a full reset pulse still ends by itself
    // a second write while armed just keeps the request armed
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            slave_dis_arm_ff <= 1'b0;
            qclr_arm_ff      <= 1'b0;
            mrst_arm_ff      <= 1'b0;
            scond_arm_ff     <= 1'b0;
            hreset_arm_ff    <= 1'b0;
            slave_dis_ff     <= 1'b0;
            qclr_ff          <= 1'b0;
            mrst_ff          <= 1'b0;
            scond_ff         <= 1'b0;
            hreset_ff        <= 1'b0;
        end else begin
            if (wr_user) begin
                slave_dis_arm_ff <= slave_dis_arm_ff |
                    reg_wdata[user_ctrl_pkg::serial_slave_disable_bit];
                qclr_arm_ff  <= qclr_arm_ff |
                    reg_wdata[user_ctrl_pkg::queue_clear_bit];
                mrst_arm_ff  <= mrst_arm_ff |
                    reg_wdata[user_ctrl_pkg::aux_master_reset_bit];
                scond_arm_ff <= scond_arm_ff |
                    reg_wdata[user_ctrl_pkg::signal_condition_reset_bit];
            end
            if (wr_pm1)
                hreset_arm_ff <= hreset_arm_ff |
                    reg_wdata[user_ctrl_pkg::full_reset_bit];
            if (tick) begin
                slave_dis_ff     <= slave_dis_arm_ff;
                qclr_ff          <= qclr_arm_ff;
                mrst_ff          <= mrst_arm_ff;
                scond_ff         <= scond_arm_ff;
                hreset_ff        <= hreset_arm_ff;
                slave_dis_arm_ff <= 1'b0;
                qclr_arm_ff      <= 1'b0;
                mrst_arm_ff      <= 1'b0;
                scond_arm_ff     <= 1'b0;
                hreset_arm_ff    <= 1'b0;
            end
        end
    end

    // aux pins: isolated master drive or pass-through of primary pins
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            aux_data_pin_out  <= 1'b1;
            aux_data_pin_oe   <= 1'b0;
            aux_clock_pin_out <= 1'b1;
            aux_clock_pin_oe  <= 1'b0;
        end else if (master_on_ff) begin
            aux_data_pin_out  <= master_sda_out;
            aux_data_pin_oe   <= master_sda_oe;
            aux_clock_pin_out <= master_scl_out;
            aux_clock_pin_oe  <= master_scl_oe;
        end else begin
            aux_data_pin_out  <= sda_s2_ff;
            aux_data_pin_oe   <= 1'b1;
            aux_clock_pin_out <= scl_s2_ff;
            aux_clock_pin_oe  <= 1'b1;
        end
    end

    assign queue_enable         = queue_on_ff;
    assign host_queue_grant     = host_queue_req & queue_on_ff;
    assign aux_master_run       = master_on_ff & ~mrst_ff;
    assign motion_processor_run = motion_processor_enable &
                                  ~rate_is_8khz;
    assign spi_only             = spi_only_ff;
    assign serial_slave_reset   = slave_dis_ff;
    assign queue_reset          = qclr_ff;
    assign aux_master_reset_out = mrst_ff;
    assign signal_condition_pulse = scond_ff;
    assign result_clear         = scond_ff;
    assign realloc_results      = all_slaves_disabled | mrst_ff;
    assign full_reset_out       = hreset_ff;
    assign sleep_mode           = sleep_ff;

    // self-clearing and reserved bits read as zero
    always_comb begin
        reg_rdata = 8'h00;
        if (sel_user) begin
            reg_rdata[user_ctrl_pkg::queue_operate_bit] = queue_on_ff;
            reg_rdata[user_ctrl_pkg::aux_master_on_bit] = master_on_ff;
        end else if (sel_pm1) begin
            // bit 7 is self-clearing and always reads as zero
            reg_rdata[user_ctrl_pkg::sleep_bit] = sleep_ff;
            reg_rdata[5:0] = pm1_low_ff;
        end
    end
endmodule : user_control_power_reset_logic

// [testbench/ucprl_checker.sv]
// Purpose: port assertions for the user control logic
// Assumes: link tick period is eight core_clk cycles
// Notes:   bound to the design top after the module
`timescale 1ns/1ns
module ucprl_checker (
    input wire logic       core_clk, rst_n, reg_wr, host_queue_req,
    input wire logic       host_queue_grant, queue_enable, aux_master_run,
    input wire logic       motion_processor_run, motion_processor_enable,
    input wire logic       rate_is_8khz, master_sda_oe, aux_data_pin_oe,
    input wire logic       queue_reset, signal_condition_pulse,
    input wire logic       realloc_results, all_slaves_disabled,
    input wire logic       aux_master_reset_out,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wdata, reg_rdata
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire logic ctl_wr = reg_wr && reg_addr == 7'h6a;
    AST_QUEUE_ON: assert property (ctl_wr |=> queue_enable == $past(reg_wdata[6]))
        else $error("queue enable wrong");
    AST_GRANT: assert property (host_queue_grant == (host_queue_req && queue_enable))
        else $error("queue grant wrong");
    AST_AUX_OWN: assert property (aux_master_run |=> aux_data_pin_oe == $past(master_sda_oe))
        else $error("aux pin not from master");
    AST_MP_RUN: assert property (motion_processor_run == (motion_processor_enable && !rate_is_8khz))
        else $error("motion run wrong");
    AST_QCLR: assert property (ctl_wr && reg_wdata[2] |-> ##[1:14] queue_reset)
        else $error("queue reset missing");
    AST_SC_WIDTH: assert property ($rose(signal_condition_pulse) |-> signal_condition_pulse[*8] ##1 !signal_condition_pulse)
        else $error("pulse width wrong");
    AST_READ_ZERO: assert property (reg_addr == 7'h6a |-> (reg_rdata & 8'h9f) == 8'h00)
        else $error("reserved bits not zero");
    AST_REALLOC: assert property (realloc_results == (all_slaves_disabled || aux_master_reset_out))
        else $error("realloc wrong");
    cover property ($rose(queue_reset));
    cover property ($rose(signal_condition_pulse));
    cover property (aux_master_run);
endmodule : ucprl_checker
bind user_control_power_reset_logic ucprl_checker u_ucprl_checker (.core_clk,
    .rst_n, .reg_wr, .host_queue_req, .host_queue_grant, .queue_enable,
    .aux_master_run, .motion_processor_run, .motion_processor_enable,
    .rate_is_8khz, .master_sda_oe, .aux_data_pin_oe, .queue_reset,
    .signal_condition_pulse, .realloc_results, .all_slaves_disabled,
    .aux_master_reset_out, .reg_addr, .reg_wdata, .reg_rdata);

// [testbench/host_pin_model.sv]
// Purpose: far-side pins: 8 MHz tick source and primary serial pins
// Assumes: tick runs free at an 800 ns period, phase unrelated to core_clk
// Notes:   primary pins change every tick so stale paths show
`timescale 1ns/1ns
module host_pin_model (
    output logic internal_8mhz_clock,
    output logic primary_sda_in,
    output logic primary_scl_in
);
    initial begin
        internal_8mhz_clock = 1'b0;
        #37;
        forever #400 internal_8mhz_clock = ~internal_8mhz_clock;
    end
    assign primary_sda_in = internal_8mhz_clock;
    assign primary_scl_in = ~internal_8mhz_clock;
endmodule : host_pin_model

// [testbench/user_control_power_reset_logic_test.sv]
// Purpose: register level tests of the user control logic
// Assumes: tick period is eight core_clk cycles
// Notes:   aux master held idle during its reset
`timescale 1ns/1ns
module user_control_power_reset_logic_test;
    logic core_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, otp_loaded = 1'b0;
    logic powerup_sleep_setting = 1'b1, motion_processor_enable = 1'b1;
    logic rate_is_8khz = 1'b1, all_slaves_disabled = 1'b0;
    logic host_queue_req = 1'b1, master_sda_out = 1'b0, master_sda_oe = 1'b0;
    logic master_scl_out = 1'b0, master_scl_oe = 1'b0, aux_data_pin_out;
    logic aux_data_pin_oe, aux_clock_pin_out, aux_clock_pin_oe, queue_enable;
    logic host_queue_grant, aux_master_run, motion_processor_run, spi_only;
    logic serial_slave_reset, queue_reset, aux_master_reset_out, result_clear;
    logic signal_condition_pulse, realloc_results, full_reset_out, sleep_mode;
    logic internal_8mhz_clock, primary_sda_in, primary_scl_in;
    logic [6:0] reg_addr = 7'h00;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    logic [7:0] cmd [4] = '{8'h10, 8'h04, 8'h02, 8'h01};
    int error_cnt = 0, n_compared = 0;
    wire logic [4:0] pv = {full_reset_out, signal_condition_pulse,
        aux_master_reset_out, queue_reset, serial_slave_reset};
    user_control_power_reset_logic u_user_control_power_reset_logic (.*);
    host_pin_model u_host_pin_model (.internal_8mhz_clock, .primary_sda_in,
        .primary_scl_in);
    task automatic chk8(input logic [7:0] e, g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("Error at %0t: expected %h got %h", $time, e, g);
        end
    endtask : chk8
    task automatic chk1(input logic e, g);
        chk8({7'h00, e}, {7'h00, g});
    endtask : chk1
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(negedge core_clk);
    endtask : wr
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        @(negedge core_clk);
        chk8(e, reg_rdata);
    endtask : rd
    task automatic pulse(input int i, input logic [6:0] a, input logic [7:0] d);
        int n;
        wr(a, d);
        for (n = 0; pv[i] !== 1'b1 && n < 20; n++) @(negedge core_clk);
        if (i == 3) chk1(1'b1, result_clear);
        for (n = 0; pv[i] === 1'b1 && n < 20; n++) @(negedge core_clk);
        chk8(8'h08, n[7:0]);
    endtask : pulse
    task automatic finish_test();
        $display("compared %0d, errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : finish_test
    initial forever #50 core_clk = ~core_clk;
    initial begin
        #1_000_000;
        error_cnt++;
        finish_test();
    end
    initial begin
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(7'h6a, user_ctrl_pkg::user_control_reset);
        rd(7'h6b, user_ctrl_pkg::pm1_low_reset);
        chk1(1'b0, motion_processor_run);
        @(posedge core_clk);
        otp_loaded <= 1'b1;
        rate_is_8khz <= 1'b0;
        repeat (2) @(negedge core_clk);
        chk1(1'b1, sleep_mode);
        chk1(1'b1, motion_processor_run);
        rd(7'h6b, 8'h41);
        wr(7'h6a, 8'h40);
        chk1(1'b1, host_queue_grant);
        rd(7'h6a, 8'h40);
        wr(7'h6a, 8'h20);
        chk1(1'b0, host_queue_grant);
        chk1(1'b1, aux_master_run);
        repeat (2) @(negedge core_clk);
        chk1(1'b0, aux_data_pin_oe);
        chk1(1'b0, aux_data_pin_out);
        wr(7'h6a, 8'h00);
        repeat (2) @(negedge core_clk);
        chk1(1'b1, aux_data_pin_oe);
        chk1(1'b1, aux_clock_pin_oe);
        chk1(~aux_data_pin_out, aux_clock_pin_out);
        chk1(1'b0, realloc_results);
        all_slaves_disabled <= 1'b1;
        @(negedge core_clk);
        chk1(1'b1, realloc_results);
        @(posedge core_clk);
        all_slaves_disabled <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            pulse(i, 7'h6a, cmd[i]);
            rd(7'h6a, 8'h00);
        end
        chk1(1'b1, spi_only);
        @(posedge core_clk);
        otp_loaded <= 1'b0;
        wr(7'h6a, 8'h40);
        pulse(4, 7'h6b, 8'h80);
        chk1(1'b0, queue_enable);
        chk1(1'b0, spi_only);
        rd(7'h6b, user_ctrl_pkg::pm1_low_reset);
        wr(7'h6b, 8'h40);
        chk1(1'b1, sleep_mode);
        rd(7'h55, 8'h00);
        finish_test();
    end
endmodule : user_control_power_reset_logic_test
